// [hw/diagnostic_event_register.sv]
// Sixteen-source diagnostic event register with AHB-Lite slave.
// Assumes fault inputs synchronous to clk and an external nonvolatile
// store that accepts a save request and answers with nv_save_done.
`timescale 1ns/100ps
`default_nettype none
`include "diag_events_params.svh"
module diagnostic_event_register
   import diag_events_pkg::*;
#(
   parameter int EVENTS = `EVENT_COUNT
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire fault_conditions_t faults,
   output nv_save_t nv_save,
   input wire logic nv_save_done,
   output event_word_t diagnostic_events,
   output logic [`COUNT_WIDTH-1:0] active_count,
   output logic irq
);

   // Population count, used for the count register
   function automatic logic [`COUNT_WIDTH-1:0] ones(input event_word_t w);
      logic [`COUNT_WIDTH-1:0] n;
      n = '0;
      for (int i = 0; i < `EVENT_COUNT; i++)
      begin
         n = n + {{(`COUNT_WIDTH-1){1'b0}}, w[i]};
      end
      return n;
   endfunction

   event_word_t status;
   event_word_t enable_word;
   event_word_t hold_word;
   logic [`IRQ_WIDTH-1:0] irq_status;
   logic [`IRQ_WIDTH-1:0] irq_enable;
   logic nv_busy;
   bus_phase_t phase;
   logic [`ADDR_DECODE_WIDTH-1:0] phase_addr;

   // Raw conditions mapped to their event bit positions
   event_word_t raw;
   assign raw[`EV_CPU_TEMP] = faults.cpu_over_temp;
   assign raw[`EV_DP_INIT] = faults.differential_pressure_sensor_init;
   assign raw[`EV_AP_INIT] = faults.absolute_pressure_sensor_init;
   assign raw[`EV_VREF] = faults.vref_range;
   assign raw[`EV_FLOW_RANGE] = faults.flow_range;
   assign raw[`EV_PRESS_RANGE] = faults.abs_press_range;
   assign raw[`EV_TEMP_RANGE] = faults.gas_temp_range;
   assign raw[`EV_AOUT_ALARM] = faults.analog_output_alarm;
   assign raw[`EV_UART_ERR] = faults.uart_error;
   assign raw[`EV_MODBUS_ERR] = faults.modbus_error;
   assign raw[`EV_NVM_ERR] = faults.nvm_error;
   assign raw[`EV_ZERO_FAIL] = faults.zero_fail;
   assign raw[`EV_TARE_FAIL] = faults.tare_fail;
   assign raw[`EV_DP_COUNTS] = faults.dp_counts_invalid;
   assign raw[`EV_AP_COUNTS] = faults.ap_counts_invalid;
   assign raw[`EV_FATAL] = faults.fatal;

   // Bus address phase capture
   wire addr_phase = hsel && hready && htrans[1];
   wire wr_now = (phase == BUS_WRITE);
   wire wr_clear_status = wr_now && (phase_addr == `OFFSET_CLEAR) && (hwdata == `CLEAR_KEY);
   wire wr_enable = wr_now && (phase_addr == `OFFSET_ENABLE);
   wire wr_hold = wr_now && (phase_addr == `OFFSET_HOLD);
   wire wr_irq_enable = wr_now && (phase_addr == `OFFSET_IRQ_ENABLE);
   wire wr_irq_clear = wr_now && (phase_addr == `OFFSET_IRQ_CLEAR);

   // Status update per bit; the clear loses to a live condition, so an
   // event present in the clearing cycle still shows afterwards.
   event_word_t next_status;
   genvar g;
   generate
      for (g = 0; g < EVENTS; g++)
      begin : gen_status
         wire held = hold_word[g] && status[g] && !wr_clear_status;
         assign next_status[g] = enable_word[g] && (raw[g] || held);
      end
   endgenerate

   wire [`COUNT_WIDTH-1:0] next_count = ones(next_status);
   wire new_event = |(next_status & ~status);
   wire config_write = wr_enable || wr_hold;
   wire [`IRQ_WIDTH-1:0] irq_events = {wr_clear_status, nv_save_done, new_event};
   wire [`IRQ_WIDTH-1:0] irq_clear_bits = wr_irq_clear ? hwdata[`IRQ_WIDTH-1:0] : '0;
   wire [`IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~irq_clear_bits) | irq_events;
   wire next_irq = |(next_irq_status & irq_enable);
   event_word_t next_enable;
   event_word_t next_hold;
   assign next_enable = wr_enable ? hwdata[`EVENT_COUNT-1:0] : enable_word;
   assign next_hold = wr_hold ? hwdata[`EVENT_COUNT-1:0] : hold_word;

   // Read mux, selected in the address phase and registered
   wire [`ADDR_DECODE_WIDTH-1:0] rd_addr = haddr[`ADDR_DECODE_WIDTH-1:0];
   logic [31:0] rd_value;
   always_comb
   begin
      case (rd_addr)
         `OFFSET_STATUS: rd_value = {16'h0000, status};
         `OFFSET_ENABLE: rd_value = {16'h0000, enable_word};
         `OFFSET_HOLD: rd_value = {16'h0000, hold_word};
         `OFFSET_ACTIVE_COUNT: rd_value = {27'h0000000, active_count};
         `OFFSET_IRQ_STATUS: rd_value = {29'h00000000, irq_status};
         `OFFSET_IRQ_ENABLE: rd_value = {29'h00000000, irq_enable};
         `OFFSET_NV_STATUS: rd_value = {31'h00000000, nv_busy};
         default: rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         phase <= BUS_IDLE;
         phase_addr <= '0;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         if (addr_phase)
         begin
            phase <= hwrite ? BUS_WRITE : BUS_READ;
            phase_addr <= rd_addr;
         end
         else
         begin
            phase <= BUS_IDLE;
         end
         hrdata <= (addr_phase && !hwrite) ? rd_value : 32'h0000_0000;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Volatile status: lost on every reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status <= '0;
         active_count <= '0;
         diagnostic_events <= '0;
      end
      else
      begin
         status <= next_status;
         active_count <= next_count;
         diagnostic_events <= next_status;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         enable_word <= `ENABLE_RESET;
         hold_word <= `HOLD_RESET;
      end
      else
      begin
         enable_word <= next_enable;
         hold_word <= next_hold;
      end
   end

   // Save request carries the words as they stand after the write;
   // a write while busy restarts the request with the newer words.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         nv_save <= '0;
         nv_busy <= 1'b0;
      end
      else
      begin
         nv_save.valid <= config_write;
         if (config_write)
         begin
            nv_save.enable_word <= next_enable;
            nv_save.hold_word <= next_hold;
         end
         nv_busy <= config_write || (nv_busy && !nv_save_done);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_status <= '0;
         irq_enable <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         if (wr_irq_enable)
         begin
            irq_enable <= hwdata[`IRQ_WIDTH-1:0];
         end
         irq <= next_irq;
      end
   end

endmodule // diagnostic_event_register
`default_nettype wire

// [shared/diag_events_params.svh]
// Constants for the diagnostic event register block.
// Included by the package and the design; definitions only.
`ifndef DIAG_EVENTS_PARAMS_SVH
`define DIAG_EVENTS_PARAMS_SVH
`define EVENT_COUNT 16
`define COUNT_WIDTH 5
// Byte offsets on the register bus
`define OFFSET_STATUS 12'h000
`define OFFSET_ENABLE 12'h004
`define OFFSET_HOLD 12'h008
`define OFFSET_CLEAR 12'h00c
`define OFFSET_ACTIVE_COUNT 12'h010
`define OFFSET_IRQ_STATUS 12'h014
`define OFFSET_IRQ_ENABLE 12'h018
`define OFFSET_IRQ_CLEAR 12'h01c
`define OFFSET_NV_STATUS 12'h020
`define ADDR_DECODE_WIDTH 12
// Reset values: only processor over-temperature enabled, no holding
`define ENABLE_RESET 16'h0001
`define HOLD_RESET 16'h0000
`define CLEAR_KEY 32'h0000_a5a5
// Event bit positions
`define EV_CPU_TEMP 0
`define EV_DP_INIT 1
`define EV_AP_INIT 2
`define EV_VREF 3
`define EV_FLOW_RANGE 4
`define EV_PRESS_RANGE 5
`define EV_TEMP_RANGE 6
`define EV_AOUT_ALARM 7
`define EV_UART_ERR 8
`define EV_MODBUS_ERR 9
`define EV_NVM_ERR 10
`define EV_ZERO_FAIL 11
`define EV_TARE_FAIL 12
`define EV_DP_COUNTS 13
`define EV_AP_COUNTS 14
`define EV_FATAL 15
// Interrupt status bits
`define IRQ_NEW_EVENT 0
`define IRQ_CONFIG_SAVE 1
`define IRQ_CLEARED 2
`define IRQ_WIDTH 3
`endif

// [shared/diag_events_pkg.sv]
// Types shared by the diagnostic event register block.
// Relies on diag_events_params.svh for widths.
`include "diag_events_params.svh"
package diag_events_pkg;
   typedef logic [`EVENT_COUNT-1:0] event_word_t;
   // Raw fault conditions from the measurement side
   typedef struct packed
   {
      logic fatal;
      logic ap_counts_invalid;
      logic dp_counts_invalid;
      logic tare_fail;
      logic zero_fail;
      logic nvm_error;
      logic modbus_error;
      logic uart_error;
      logic analog_output_alarm;
      logic gas_temp_range;
      logic abs_press_range;
      logic flow_range;
      logic vref_range;
      logic absolute_pressure_sensor_init;
      logic differential_pressure_sensor_init;
      logic cpu_over_temp;
   } fault_conditions_t;
   // Request to the nonvolatile store
   typedef struct packed
   {
      logic valid;
      event_word_t enable_word;
      event_word_t hold_word;
   } nv_save_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_phase_t;
endpackage

// [tb/diag_events_chk.sv]
// Port checker for the diagnostic event register.
// Assumes one clock, synchronous reset; bound to every design instance.
`timescale 1ns/100ps
`default_nettype none
`include "diag_events_params.svh"
module diag_events_chk
   import diag_events_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire fault_conditions_t faults,
   input wire nv_save_t nv_save,
   input wire event_word_t diagnostic_events,
   input wire logic [`COUNT_WIDTH-1:0] active_count,
   input wire logic irq
);
   wire logic take = hsel && hready && htrans[1];
   wire logic cfg_wr = take && hwrite && (haddr[11:0] == `OFFSET_ENABLE || haddr[11:0] == `OFFSET_HOLD);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Faults idle in the data phase so nothing may survive the clear
   sequence clear_wr;
      take && hwrite && haddr[11:0] == `OFFSET_CLEAR ##1 hwdata == `CLEAR_KEY && faults == '0;
   endsequence
   chk_clear_drop: assert property (clear_wr |=> diagnostic_events == '0)
      else $error("status kept after keyed clear");
   chk_count_pop: assert property (active_count == $countones(diagnostic_events))
      else $error("active count differs from status");
   chk_no_phantom: assert property ((diagnostic_events & ~$past(diagnostic_events) & ~event_word_t'($past(faults))) == '0)
      else $error("status bit rose without its condition");
   chk_reset_empty: assert property ($fell(rst) |-> diagnostic_events == '0 && active_count == '0 && !irq)
      else $error("state not cleared by reset");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   chk_rdata_idle: assert property (!$past(take && !hwrite) |-> hrdata == '0)
      else $error("read data outside data phase");
   chk_save_pulse: assert property (nv_save.valid |=> !nv_save.valid)
      else $error("save request longer than one cycle");
   chk_save_cause: assert property (nv_save.valid |-> $past(cfg_wr, 2) || $past(cfg_wr, 3))
      else $error("save request without config write");
endmodule // diag_events_chk
bind diagnostic_event_register diag_events_chk chk_u (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hrdata, .hreadyout, .hresp, .faults, .nv_save, .diagnostic_events, .active_count, .irq);
`default_nettype wire

// [tb/diagnostic_event_register_test.sv]
// Testbench for the diagnostic event register.
// Drives the AHB-Lite slave directly; the store model answers saves.
`timescale 1ns/100ps
`default_nettype none
`include "diag_events_params.svh"
module diagnostic_event_register_test;
   import diag_events_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic hsel = 0;
   logic hwrite = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] hrdata, r;
   logic hready, hreadyout, hresp, irq, nv_save_done;
   fault_conditions_t faults = '0;
   nv_save_t nv_save;
   event_word_t diagnostic_events, sav_en, sav_hold;
   logic [`COUNT_WIDTH-1:0] active_count;
   int n_errors = 0;
   int samples_checked = 0;
   assign hready = hreadyout;
   always #12.5 clk = ~clk;
   diagnostic_event_register dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .faults(faults), .nv_save(nv_save), .nv_save_done(nv_save_done),
      .diagnostic_events(diagnostic_events), .active_count(active_count), .irq(irq));
   nv_store_model nv_u (.clk(clk), .rst(rst), .nv_save(nv_save), .nv_save_done(nv_save_done),
      .saved_enable(sav_en), .saved_hold(sav_hold));
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(r, exp);
   endtask
   task pulse(input logic [15:0] f);
      faults <= fault_conditions_t'(f);
      tick(1);
      faults <= '0;
      tick(3);
   endtask
   task end_sim;
      $display("checked %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
   initial
   begin
      tick(20);
      rst <= 1'b0;
      rdchk(`OFFSET_STATUS, 32'h0);
      rdchk(`OFFSET_ENABLE, 32'h1);
      rdchk(`OFFSET_HOLD, 32'h0);
      rdchk(12'h040, 32'h0);
      rdchk(`OFFSET_NV_STATUS, 32'h0);
      $display("test reset values done");
      faults <= fault_conditions_t'(16'hffff);
      tick(2);
      check(diagnostic_events, 16'h0001);
      bus(1'b1, `OFFSET_ENABLE, 32'hffff);
      tick(6);
      check(active_count, 5'd16);
      check(sav_en, 16'hffff);
      for (int i = 0; i < 16; i++)
      begin
         faults <= fault_conditions_t'(16'h1 << i);
         tick(2);
         check(diagnostic_events, 16'h1 << i);
      end
      rdchk(`OFFSET_STATUS, 32'h8000);
      rdchk(`OFFSET_ACTIVE_COUNT, 32'h1);
      $display("test event mapping done");
      bus(1'b1, `OFFSET_HOLD, 32'h0010);
      bus(1'b1, `OFFSET_IRQ_ENABLE, 32'h1);
      pulse(16'h0030);
      check(diagnostic_events, 16'h0010);
      check(sav_hold, 16'h0010);
      check(irq, 1'b1);
      rdchk(`OFFSET_IRQ_STATUS, 32'h3);
      bus(1'b1, `OFFSET_STATUS, 32'hffff);
      bus(1'b1, `OFFSET_CLEAR, 32'h1234);
      tick(2);
      check(diagnostic_events, 16'h0010);
      bus(1'b1, `OFFSET_CLEAR, `CLEAR_KEY);
      tick(2);
      check(diagnostic_events, 16'h0);
      rdchk(`OFFSET_IRQ_STATUS, 32'h7);
      bus(1'b1, `OFFSET_IRQ_CLEAR, 32'h7);
      tick(2);
      check(irq, 1'b0);
      bus(1'b1, `OFFSET_IRQ_ENABLE, 32'h0);
      pulse(16'h0001);
      check(irq, 1'b0);
      bus(1'b1, `OFFSET_IRQ_ENABLE, 32'h1);
      tick(2);
      check(irq, 1'b1);
      faults <= fault_conditions_t'(16'h0001);
      bus(1'b1, `OFFSET_ENABLE, 32'hfffe);
      tick(3);
      check(diagnostic_events, 16'h0);
      $display("test hold and clear done");
      bus(1'b1, `OFFSET_HOLD, 32'hffff);
      pulse(16'h00f0);
      check(diagnostic_events, 16'h00f0);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(1);
      check(diagnostic_events, 16'h0);
      rdchk(`OFFSET_ENABLE, 32'h1);
      check(sav_en, 16'hfffe);
      $display("test reset in run done");
      end_sim();
   end
endmodule // diagnostic_event_register_test
`default_nettype wire

// [tb/nv_store_model.sv]
// Nonvolatile store model for configuration saves.
// Answers a save LAT cycles after it; a newer save restarts the count; contents survive rst.
`timescale 1ns/100ps
`default_nettype none
module nv_store_model
   import diag_events_pkg::*;
#(
   parameter int LAT = 3
)
(
   input wire logic clk,
   input wire logic rst,
   input wire nv_save_t nv_save,
   output logic nv_save_done,
   output event_word_t saved_enable,
   output event_word_t saved_hold
);
   int wait_cnt;
   always_ff @(posedge clk)
   begin
      nv_save_done <= 1'b0;
      if (rst)
         wait_cnt <= 0;
      else if (nv_save.valid)
      begin
         saved_enable <= nv_save.enable_word;
         saved_hold <= nv_save.hold_word;
         wait_cnt <= LAT;
      end
      else if (wait_cnt > 0)
      begin
         wait_cnt <= wait_cnt - 1;
         nv_save_done <= (wait_cnt == 1);
      end
   end
endmodule // nv_store_model
`default_nettype wire
